// [design/osc_sleep_pkg.sv]
// Shared constants, types and register map of the oscillator trim and sleep controller
package osc_sleep_pkg;

    // ************************************
    // Register indices (byte address = 4 * index)
    // ************************************
    localparam logic [7:0] IDX_MAIN_TRIM  = 8'h63;
    localparam logic [7:0] IDX_TEMP_SLOPE = 8'h64;
    localparam logic [7:0] IDX_TEMP_CTRL  = 8'h65;
    localparam logic [7:0] IDX_LP_TRIM    = 8'h66;
    localparam logic [7:0] IDX_CORE_CTRL  = 8'h67;
    localparam logic [7:0] IDX_STATUS     = 8'h68;

    // ************************************
    // Field positions
    // ************************************
    localparam int SLOPE_SIGN_BIT = 7;
    localparam int COMP_EN_BIT    = 7;
    localparam int SLEEP_ARM_BIT  = 4;
    localparam int MODE_LSB       = 5;
    localparam int LP_TRIM_W      = 2;

    // ************************************
    // Reset values and timing counts
    // ************************************
    localparam logic [7:0] CORE_CTRL_RESET      = 8'h00;
    localparam logic [7:0] CORE_CTRL_MASK       = 8'h70;
    localparam logic [7:0] STEP_SMALLEST        = 8'h7f;
    localparam logic [3:0] STALL_CYCLES         = 4'h4;
    localparam logic [3:0] STANDBY_WAKE_CYCLES  = 4'h6;
    localparam logic [3:0] STANDBY_START_CYCLES = STANDBY_WAKE_CYCLES - STALL_CYCLES;
    localparam logic [3:0] PDOWN_START_CYCLES   = 4'h6;

    // ************************************
    // Types
    // ************************************
    typedef enum logic [1:0] {
        MODE_IDLE,
        MODE_ADC_NR,
        MODE_POWER_DOWN,
        MODE_STANDBY
    } sleep_mode_t;

    typedef enum logic [1:0] {
        ST_ACTIVE,
        ST_SLEEP,
        ST_STARTUP,
        ST_STALL
    } sleep_state_t;

    typedef struct packed {
        logic [7:0] main_trim;
        logic [7:0] temp_slope;
        logic [7:0] temp_control;
        logic [1:0] lp_trim;
    } factory_cal_t;

    typedef struct packed {
        logic watchdog;
        logic ext_irq;
        logic ext_level_mode;
        logic pin_change;
        logic adc_done;
        logic nvm_ready;
        logic usi_start;
        logic usart_start_frame;
        logic twi_addr_match;
        logic other_irq;
    } wake_src_t;

    typedef struct packed {
        logic main_osc;
        logic core;
        logic program_memory;
        logic peripheral;
        logic converter;
    } clock_en_t;

    typedef struct packed {
        logic [7:0] main_trim_value;
        logic       comp_enable;
        logic       slope_sign;
        logic [6:0] slope_magnitude;
        logic [6:0] slope_step_size;
        logic [1:0] low_power_trim_value;
    } osc_trim_t;

endpackage

// [design/domain_clock_gate.sv]
// Registered, glitch-free run enable for one gated clock domain
`timescale 1ns/100ps
module domain_clock_gate
    import osc_sleep_pkg::*;
(
    // Clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // Request and gate enable
    input  wire logic run_req,
    output logic      run_en
);

    logic next_run_en;

    // Enable only changes at a clock edge, so the downstream gate never chops a pulse
    always_comb begin
        next_run_en = run_req;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_en <= 1'b1;
        end else begin
            run_en <= next_run_en;
        end
    end

endmodule

// [design/osc_trim_and_sleep_control.sv]
// Oscillator trim registers and sleep-mode clock controller with AHB-Lite access
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/100ps
// What this block does
// RL1 - Eight-bit main trim sets 8 MHz oscillator; zero slowest, larger faster.
// RL2 - Every reset loads factory values into main trim, slope and control registers.
// RL3 - Software keeps main trim at or below 8.8 MHz during memory writes.
// RL4 - Software changes main trim by at most 0x20 per step, or holds reset.
// RL5 - Slope register is sign-magnitude: bit 7 sign, bits 6:0 magnitude.
// RL6 - Compensation enable bit 7 applies both temperature registers, else no effect.
// RL7 - Step adjust bits 6:0 scale slope step; 0x00 largest, 0x7F smallest.
// RL8 - Low-power oscillator trim uses bits 1:0; bits 7:2 read zero.
// RL9 - Software readjusts main trim whenever compensation is toggled.
// RL10 - Sleep entered only with arm bit set and sleep instruction; mode bits select.
// RL11 - Mode field bits 6:5: Idle, ADC noise reduction, Power-down, Standby.
// RL12 - Wake stalls core four cycles after start-up, then handler runs.
// RL13 - State kept across sleep; reset during sleep restarts from reset vector.
// RL14 - Idle stops core and program memory clocks only; any interrupt wakes.
// RL15 - Entering Idle or ADC noise reduction with ADC enabled starts conversion.
// RL16 - ADC noise reduction stops peripheral, core, memory clocks; listed sources wake.
// RL17 - Power-down stops oscillator and all clocks; listed asynchronous sources wake.
// RL18 - Standby equals Power-down but oscillator runs; wake within six cycles.
// RL19 - Outside Idle the external line wakes only when level-triggered.
// RL20 - Level wake source holds its level until the handler is entered.
// RL21 - Domains gate glitch-free; sleep arm bit is never cleared by wake-up.
module osc_trim_and_sleep_control
    import osc_sleep_pkg::*;
(
    // Clock and reset
    input  wire logic          hclk,
    input  wire logic          hresetn,
    // AHB-Lite slave
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output logic               hreadyout,
    output logic               hresp,
    output logic [31:0]        hrdata,
    // Factory calibration values
    input  wire factory_cal_t  factory_cal,
    // Core side
    input  wire logic          sleep_instr,
    input  wire logic          adc_enabled,
    output logic               core_stall,
    output logic               wake_pulse,
    output logic               adc_start,
    // Wake-up sources
    input  wire wake_src_t     wake_src,
    // Oscillator trims and clock domain enables
    output osc_trim_t          osc_trim,
    output clock_en_t          clock_en
);

    // ************************************
    // Declarations
    // ************************************
    logic [7:0]   main_osc_trim;
    logic [7:0]   main_osc_temp_slope;
    logic [7:0]   main_osc_temp_control;
    logic [1:0]   low_power_trim_value;
    logic [7:0]   core_control_register;
    logic         cal_loaded;
    logic [7:0]   next_main_osc_trim;
    logic [7:0]   next_main_osc_temp_slope;
    logic [7:0]   next_main_osc_temp_control;
    logic [1:0]   next_low_power_trim_value;
    logic [7:0]   next_core_control_register;
    logic         next_cal_loaded;

    logic         dphase_write;
    logic [7:0]   dphase_index;
    logic         next_dphase_write;
    logic [7:0]   next_dphase_index;
    logic [31:0]  next_hrdata;
    logic         aphase_valid;

    sleep_state_t state;
    sleep_state_t next_state;
    sleep_mode_t  active_mode;
    sleep_mode_t  next_active_mode;
    logic [3:0]   wait_count;
    logic [3:0]   next_wait_count;
    logic         next_wake_pulse;
    logic         next_adc_start;
    osc_trim_t    next_osc_trim;
    clock_en_t    domain_req;
    clock_en_t    domain_en;

    logic         sleep_arm_bit;
    sleep_mode_t  sleep_mode_select;

    // ************************************
    // Decode helpers
    // ************************************
    function automatic logic hits_block(input logic [31:0] addr);
        hits_block = (addr[31:10] == 22'h000000) && (addr[1:0] == 2'b00);
    endfunction

    function automatic logic [7:0] read_reg(
        input logic [7:0] idx,
        input logic [7:0] trim,
        input logic [7:0] slope,
        input logic [7:0] ctrl,
        input logic [1:0] lp,
        input logic [7:0] core,
        input logic [7:0] stat
    );
        case (idx)
            IDX_MAIN_TRIM:  read_reg = trim;
            IDX_TEMP_SLOPE: read_reg = slope;
            IDX_TEMP_CTRL:  read_reg = ctrl;
            IDX_LP_TRIM:    read_reg = {6'h00, lp}; // RL8
            IDX_CORE_CTRL:  read_reg = core;
            IDX_STATUS:     read_reg = stat;
            default:        read_reg = 8'h00;
        endcase
    endfunction

    // Which enabled sources may end the given sleep mode
    function automatic logic wake_allowed(input sleep_mode_t mode, input wake_src_t w);
        logic level_ext;
        logic deep;
        level_ext = w.ext_irq && w.ext_level_mode; // RL19
        deep = w.watchdog || level_ext || w.pin_change || w.usi_start
            || w.usart_start_frame || w.twi_addr_match;
        case (mode)
            MODE_IDLE:       wake_allowed = (|{w[9:8], w[6:0]}); // RL14
            MODE_ADC_NR:     wake_allowed = deep || w.adc_done || w.nvm_ready; // RL16
            MODE_POWER_DOWN: wake_allowed = deep; // RL17
            MODE_STANDBY:    wake_allowed = deep; // RL18
            default:         wake_allowed = 1'b0;
        endcase
    endfunction

    assign sleep_arm_bit     = core_control_register[SLEEP_ARM_BIT];
    assign sleep_mode_select = sleep_mode_t'(core_control_register[MODE_LSB +: 2]); // RL11

    // ************************************
    // AHB-Lite slave
    // ************************************
    assign aphase_valid = hsel && hready && htrans[1] && hits_block(haddr);
    assign hreadyout    = 1'b1;
    assign hresp        = 1'b0;

    always_comb begin
        next_dphase_write = aphase_valid && hwrite;
        next_dphase_index = haddr[9:2];
        next_hrdata       = hrdata;
        if (aphase_valid && !hwrite) begin
            next_hrdata = {24'h000000, read_reg(haddr[9:2], next_main_osc_trim,
                next_main_osc_temp_slope, next_main_osc_temp_control,
                next_low_power_trim_value, next_core_control_register,
                {6'h00, state})};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dphase_write <= 1'b0;
            dphase_index <= 8'h00;
            hrdata       <= 32'h00000000;
        end else begin
            dphase_write <= next_dphase_write;
            dphase_index <= next_dphase_index;
            hrdata       <= next_hrdata;
        end
    end

    // ************************************
    // Calibration and control registers
    // ************************************
    always_comb begin
        next_main_osc_trim         = main_osc_trim;
        next_main_osc_temp_slope   = main_osc_temp_slope;
        next_main_osc_temp_control = main_osc_temp_control;
        next_low_power_trim_value  = low_power_trim_value;
        next_core_control_register = core_control_register;
        next_cal_loaded            = 1'b1;
        if (!cal_loaded) begin
            next_main_osc_trim         = factory_cal.main_trim; // RL2
            next_main_osc_temp_slope   = factory_cal.temp_slope; // RL2
            next_main_osc_temp_control = factory_cal.temp_control; // RL2
            next_low_power_trim_value  = factory_cal.lp_trim;
        end else if (dphase_write) begin
            case (dphase_index)
                IDX_MAIN_TRIM:  next_main_osc_trim = hwdata[7:0]; // RL1
                IDX_TEMP_SLOPE: next_main_osc_temp_slope = hwdata[7:0]; // RL5
                IDX_TEMP_CTRL:  next_main_osc_temp_control = hwdata[7:0];
                IDX_LP_TRIM:    next_low_power_trim_value = hwdata[LP_TRIM_W-1:0]; // RL8
                IDX_CORE_CTRL:  next_core_control_register = hwdata[7:0] & CORE_CTRL_MASK;
                default:        next_cal_loaded = 1'b1;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            main_osc_trim         <= 8'h00;
            main_osc_temp_slope   <= 8'h00;
            main_osc_temp_control <= 8'h00;
            low_power_trim_value  <= 2'h0;
            core_control_register <= CORE_CTRL_RESET;
            cal_loaded            <= 1'b0;
        end else begin
            main_osc_trim         <= next_main_osc_trim;
            main_osc_temp_slope   <= next_main_osc_temp_slope;
            main_osc_temp_control <= next_main_osc_temp_control;
            low_power_trim_value  <= next_low_power_trim_value;
            core_control_register <= next_core_control_register;
            cal_loaded            <= next_cal_loaded;
        end
    end

    // ************************************
    // Oscillator trim outputs
    // ************************************
    always_comb begin
        next_osc_trim.main_trim_value      = main_osc_trim; // RL1
        next_osc_trim.comp_enable          = main_osc_temp_control[COMP_EN_BIT]; // RL6
        next_osc_trim.slope_sign           = 1'b0;
        next_osc_trim.slope_magnitude      = 7'h00;
        next_osc_trim.slope_step_size      = 7'h00;
        next_osc_trim.low_power_trim_value = low_power_trim_value; // RL8
        if (main_osc_temp_control[COMP_EN_BIT]) begin
            next_osc_trim.slope_sign      = main_osc_temp_slope[SLOPE_SIGN_BIT]; // RL5
            next_osc_trim.slope_magnitude = main_osc_temp_slope[6:0]; // RL5
            next_osc_trim.slope_step_size = STEP_SMALLEST[6:0]
                - main_osc_temp_control[6:0]; // RL7
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            osc_trim <= '0;
        end else begin
            osc_trim <= next_osc_trim;
        end
    end

    // ************************************
    // Sleep sequencer
    // ************************************
    always_comb begin
        next_state       = state;
        next_active_mode = active_mode;
        next_wait_count  = wait_count;
        next_wake_pulse  = 1'b0;
        next_adc_start   = 1'b0;
        case (state)
            ST_ACTIVE: begin
                if (sleep_instr && sleep_arm_bit) begin // RL10
                    next_state       = ST_SLEEP;
                    next_active_mode = sleep_mode_select; // RL10
                    next_adc_start   = adc_enabled && ((sleep_mode_select == MODE_IDLE)
                        || (sleep_mode_select == MODE_ADC_NR)); // RL15
                end
            end
            ST_SLEEP: begin
                if (wake_allowed(active_mode, wake_src)) begin
                    next_state = ST_STARTUP;
                    case (active_mode)
                        MODE_POWER_DOWN: next_wait_count = PDOWN_START_CYCLES; // RL17
                        MODE_STANDBY:    next_wait_count = STANDBY_START_CYCLES; // RL18
                        default:         next_wait_count = 4'h1;
                    endcase
                end
            end
            ST_STARTUP: begin
                next_wait_count = wait_count - 4'h1;
                if (wait_count == 4'h1) begin
                    next_state      = ST_STALL;
                    next_wait_count = STALL_CYCLES; // RL12
                end
            end
            ST_STALL: begin
                next_wait_count = wait_count - 4'h1;
                if (wait_count == 4'h1) begin
                    next_state      = ST_ACTIVE; // RL12
                    next_wake_pulse = 1'b1; // RL12
                end
            end
            default: begin
                next_state = ST_ACTIVE;
            end
        endcase
    end

    // Reset during sleep returns straight to active, trim registers reload from factory, core control reloads CORE_CTRL_RESET
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state       <= ST_ACTIVE; // RL13
            active_mode <= MODE_IDLE;
            wait_count  <= 4'h0;
            wake_pulse  <= 1'b0;
            adc_start   <= 1'b0;
        end else begin
            state       <= next_state;
            active_mode <= next_active_mode;
            wait_count  <= next_wait_count;
            wake_pulse  <= next_wake_pulse;
            adc_start   <= next_adc_start;
        end
    end

    assign core_stall = (state != ST_ACTIVE);

    // ************************************
    // Clock domain requests
    // ************************************
    always_comb begin
        domain_req = '1;
        if (state == ST_SLEEP || state == ST_STARTUP) begin
            domain_req.core           = 1'b0; // RL14
            domain_req.program_memory = 1'b0; // RL14
            case (active_mode)
                MODE_IDLE: begin
                    domain_req.peripheral = 1'b1; // RL14
                end
                MODE_ADC_NR: begin
                    domain_req.peripheral = 1'b0; // RL16
                end
                MODE_STANDBY: begin
                    domain_req.peripheral = 1'b0; // RL18
                    domain_req.converter  = 1'b0; // RL18
                end
                default: begin
                    domain_req = '0; // RL17
                end
            endcase
            if (state == ST_STARTUP) begin
                domain_req.main_osc = 1'b1;
            end
        end else if (state == ST_STALL) begin
            domain_req.core           = 1'b0; // RL12
            domain_req.program_memory = 1'b0;
        end
    end

    // Each domain gets its own registered gate enable
    for (genvar g = 0; g < 5; g++) begin : gen_gate
        domain_clock_gate u_gate (
            .hclk    (hclk),
            .hresetn (hresetn),
            .run_req (domain_req[g]),
            .run_en  (domain_en[g])
        ); // RL21
    end

    assign clock_en = domain_en;

endmodule

// [sim/osc_sleep_assertions.sv]
// Port-level checks of the oscillator trim and sleep controller
`timescale 1ns/100ps
module osc_sleep_assertions
    import osc_sleep_pkg::*;
(
    // Clock, reset and bus answer
    input wire logic         hclk,
    input wire logic         hresetn,
    input wire logic         hreadyout,
    input wire logic         hresp,
    // Core side and trims
    input wire factory_cal_t factory_cal,
    input wire logic         sleep_instr,
    input wire logic         core_stall,
    input wire logic         wake_pulse,
    input wire logic         adc_start,
    input wire osc_trim_t    osc_trim,
    input wire clock_en_t    clock_en
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ************************************
    // Sleep entry and exit, clock gating, trims and bus answer
    // ************************************
    sequence s_enter;
        sleep_instr ##1 core_stall;
    endsequence
    sequence s_leave;
        core_stall ##1 !core_stall;
    endsequence
    AST_SLEEP_CAUSE: assert property ($rose(core_stall) |-> $past(sleep_instr))
        else $error("stall began without a sleep request");
    AST_WAKE_STALL: assert property (s_enter |=> core_stall [*4])
        else $error("core released too early after sleep");
    AST_WAKE_PULSE: assert property (s_leave |-> ##[0:1] wake_pulse)
        else $error("no wake pulse on return to active");
    AST_ACTIVE_CLOCKS: assert property (!core_stall ##1 !core_stall |-> clock_en == 5'h1f)
        else $error("clock domain gated while active");
    AST_CORE_MEM_PAIR: assert property (clock_en.core == clock_en.program_memory)
        else $error("core and memory clocks differ");
    AST_OSC_OFF_ALL: assert property (!clock_en.main_osc |-> clock_en == 5'h00)
        else $error("clock running with oscillator stopped");
    AST_ADC_START: assert property (adc_start |-> core_stall && clock_en.converter ##1 !adc_start)
        else $error("conversion start outside sleep entry");
    AST_COMP_OFF: assert property (!osc_trim.comp_enable |->
        {osc_trim.slope_sign, osc_trim.slope_magnitude, osc_trim.slope_step_size} == 15'h0)
        else $error("slope applied with compensation off");
    AST_RESET_LOAD: assert property ($rose(hresetn) |-> ##2
        osc_trim.main_trim_value == factory_cal.main_trim
        && osc_trim.low_power_trim_value == factory_cal.lp_trim)
        else $error("factory trim not loaded after reset");
    AST_BUS_OKAY: assert property (hreadyout && !hresp)
        else $error("bus answer not ready and okay");
endmodule
bind osc_trim_and_sleep_control osc_sleep_assertions osc_sleep_assertions_inst (
    .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
    .factory_cal(factory_cal), .sleep_instr(sleep_instr), .core_stall(core_stall),
    .wake_pulse(wake_pulse), .adc_start(adc_start), .osc_trim(osc_trim), .clock_en(clock_en));

// [sim/core_wake_model.sv]
// Core and wake-source model facing the sleep controller
`timescale 1ns/100ps
module core_wake_model
    import osc_sleep_pkg::*;
(
    // Clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // Commands from the bench
    input  wire logic       sleep_go,
    input  wire wake_src_t  wake_cmd,
    input  wire logic [3:0] wake_delay,
    // Controller side
    input  wire logic       core_stall,
    input  wire logic       wake_pulse,
    output logic            sleep_instr,
    output wake_src_t       wake_src
);
    logic [3:0] cnt;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sleep_instr <= 1'b0;
            wake_src    <= '0;
            cnt         <= 4'h0;
        end else begin
            sleep_instr <= sleep_go && !core_stall && !sleep_instr;
            if (wake_pulse || !core_stall) begin
                wake_src <= '0;
                cnt      <= 4'h0;
            end else if (cnt < wake_delay) begin
                cnt <= cnt + 4'h1;
            end else begin
                wake_src <= wake_cmd;
            end
        end
    end
endmodule

// [sim/osc_trim_and_sleep_control_tb.sv]
// Self-checking bench of the oscillator trim and sleep controller
`timescale 1ns/100ps
module osc_trim_and_sleep_control_tb
    import osc_sleep_pkg::*;
;
    logic         hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0]  haddr, hwdata, hrdata, r;
    logic [1:0]   htrans;
    logic [2:0]   hsize;
    logic         core_stall, wake_pulse, adc_start, adc_enabled, sleep_instr, sleep_go, rd_dp;
    logic [7:0]   t;
    logic [25:0]  e;
    logic [4:0]   ce_exp [4] = '{5'h13, 5'h11, 5'h00, 5'h10};
    factory_cal_t fc;
    wake_src_t    wake_src, wake_cmd;
    osc_trim_t    osc_trim;
    clock_en_t    clock_en;
    logic [31:0]  rd_q [$];
    int           error_cnt, cmp_count, adc_cnt;

    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    osc_trim_and_sleep_control osc_trim_and_sleep_control_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .factory_cal(fc),
        .sleep_instr(sleep_instr), .adc_enabled(adc_enabled), .core_stall(core_stall),
        .wake_pulse(wake_pulse), .adc_start(adc_start), .wake_src(wake_src),
        .osc_trim(osc_trim), .clock_en(clock_en));
    core_wake_model core_wake_model_inst (
        .hclk(hclk), .hresetn(hresetn), .sleep_go(sleep_go), .wake_cmd(wake_cmd),
        .wake_delay(4'h2), .core_stall(core_stall), .wake_pulse(wake_pulse),
        .sleep_instr(sleep_instr), .wake_src(wake_src));

    // ************************************
    // Compare, monitor and bus tasks
    // ************************************
    task automatic check(input string nm, input logic [31:0] ex, input logic [31:0] g);
        cmp_count++;
        if (g !== ex) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, g);
        end
    endtask
    always @(posedge hclk) begin
        if (rd_dp === 1'b1)
            check("hrdata", rd_q.pop_front(), hrdata);
        rd_dp <= hsel && htrans[1] && !hwrite && hreadyout;
        if (adc_start === 1'b1)
            adc_cnt++;
    end
    task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        hsize  <= 3'b010;
        haddr  <= {22'h0, idx, 2'b00};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= w ? d : 32'h0;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [31:0] ex);
        rd_q.push_back(ex);
        bus(1'b0, idx, 32'h0);
    endtask
    task automatic do_reset(input int n);
        hresetn <= 1'b0;
        repeat (n) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
    endtask
    task automatic go();
        sleep_go <= 1'b1;
        @(posedge hclk);
        sleep_go <= 1'b0;
    endtask
    task automatic nap(input logic [1:0] m, input wake_src_t bad, input wake_src_t good,
                       input int s);
        int n;
        int a0;
        a0 = adc_cnt;
        bus(1'b1, IDX_CORE_CTRL, {25'h0, m, 1'b1, 4'h0});
        go();
        n = 0;
        while (core_stall !== 1'b1 && n < 20) begin
            @(posedge hclk);
            n++;
        end
        repeat (3) @(posedge hclk);
        check("clock_en", {27'h0, ce_exp[m]}, {27'h0, clock_en});
        wake_cmd <= bad;
        repeat (12) @(posedge hclk);
        check("stall_kept", 32'h1, {31'h0, core_stall});
        wake_cmd <= good;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (core_stall === 1'b1 && n < 40);
        wake_cmd <= '0;
        check("wake_cycles", 32'(s + 7), 32'(n));
        check("adc_start", {31'h0, m < 2'd2}, 32'(adc_cnt - a0));
        rd(IDX_CORE_CTRL, {25'h0, m, 1'b1, 4'h0});
        $display("test sleep mode %0d done", m);
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ************************************
    // Tests
    // ************************************
    initial begin
        hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0;
        hsize = 3'b010; hwdata = 32'h0; sleep_go = 1'b0; wake_cmd = '0;
        adc_enabled = 1'b1; error_cnt = 0; cmp_count = 0; adc_cnt = 0;
        void'($urandom(32'h3832));
        r = $urandom;
        fc = r[25:0];
        do_reset(8);
        rd(IDX_MAIN_TRIM, {24'h0, fc.main_trim});
        rd(IDX_TEMP_SLOPE, {24'h0, fc.temp_slope});
        rd(IDX_TEMP_CTRL, {24'h0, fc.temp_control});
        rd(IDX_LP_TRIM, {30'h0, fc.lp_trim});
        rd(IDX_CORE_CTRL, {24'h0, CORE_CTRL_RESET});
        rd(8'h70, 32'h0);
        $display("test reset values done");
        for (int c = 1; c >= 0; c--) begin
            r = $urandom;
            t = fc.main_trim ^ {3'h0, r[31:27]};
            bus(1'b1, IDX_TEMP_SLOPE, {24'h0, r[7:0]});
            bus(1'b1, IDX_TEMP_CTRL, {24'h0, c[0], r[14:8]});
            bus(1'b1, IDX_MAIN_TRIM, {24'h0, t});
            bus(1'b1, IDX_LP_TRIM, {24'h0, r[23:16]});
            rd(IDX_LP_TRIM, {30'h0, r[17:16]});
            rd(IDX_TEMP_SLOPE, {24'h0, r[7:0]});
            repeat (2) @(posedge hclk);
            e = {t, c[0], c[0] & r[7], r[6:0] & {7{c[0]}},
                 (STEP_SMALLEST[6:0] - r[14:8]) & {7{c[0]}}, r[17:16]};
            check("osc_trim", {6'h0, e}, {6'h0, osc_trim});
        end
        bus(1'b1, IDX_CORE_CTRL, 32'hff);
        rd(IDX_CORE_CTRL, {24'h0, CORE_CTRL_MASK});
        bus(1'b1, IDX_STATUS, 32'h3);
        rd(IDX_STATUS, 32'h0);
        bus(1'b1, IDX_CORE_CTRL, 32'h0);
        go();
        repeat (5) @(posedge hclk);
        check("unarmed_stall", 32'h0, {31'h0, core_stall});
        $display("test registers done");
        nap(2'd0, '0, wake_src_t'(10'h100), 1);
        nap(2'd1, wake_src_t'(10'h100), wake_src_t'(10'h020), 1);
        nap(2'd2, wake_src_t'(10'h100), wake_src_t'(10'h180), PDOWN_START_CYCLES);
        nap(2'd3, wake_src_t'(10'h100), wake_src_t'(10'h002), STANDBY_START_CYCLES);
        bus(1'b1, IDX_MAIN_TRIM, {24'h0, t ^ 8'h20});
        bus(1'b1, IDX_CORE_CTRL, 32'h50);
        go();
        repeat (6) @(posedge hclk);
        check("asleep", 32'h1, {31'h0, core_stall});
        do_reset(2);
        check("reset_wake", 32'h0, {31'h0, core_stall});
        rd(IDX_MAIN_TRIM, {24'h0, fc.main_trim});
        rd(IDX_CORE_CTRL, 32'h0);
        $display("test reset in sleep done");
        end_sim();
    end

    initial begin
        #(8 * 20000);
        error_cnt++;
        end_sim();
    end
endmodule
